/* File: hw/adm_fifo.sv */
`timescale 1ns/1ps

module adm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_flush,
    input  wire logic                         i_in_valid,
    output logic                              o_in_ready,
    input  wire logic [WIDTH-1:0]             i_in_data,
    output logic                              o_out_valid,
    input  wire logic                         i_out_ready,
    output logic [WIDTH-1:0]                  o_out_data,
    output logic [$clog2(DEPTH+1)-1:0]        o_level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [CW-1:0]    cnt_q;
    logic             push;
    logic             pop;

    // Handshakes on both sides
    assign o_in_ready  = (cnt_q != CW'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_q];
    assign o_level     = cnt_q;

    // Storage
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
        end
    end

    // Fill level
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_flush) begin
            cnt_q <= '0;
        end else if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule

/* File: hw/adm_out_ctrl.sv */
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "adm_regs.svh"

// Function
// R1: Sample reaches bank selection 2.5 sample cycles after it is taken; here bank A updates 4 sample cycles after it is taken in single mode.
// R2: Each pipeline stage decodes no more than three result bits.
// R3: Three LSBs are latched one full cycle after the three MSBs; the pipeline latches them two cycles after.
// R4: Mode pins: 00 parallel, 01 interleaved, 1X single bank.
// R5: Single mode drives every sample on bank A; clock limited to 125 MSPS.
// R6: Interleaved mode alternates samples between bank A and bank B.
// R7: Parallel mode delays bank A one cycle so both banks update together.
// R8: Dual modes divide the clock by two; divided phase picks the bank.
// R9: Reset input aligns the divide-by-two phase, fixing bank assignment.
// R10: Output clock latches data in single mode, shows bank in dual.
// R11: Power-down high gives low power and tri-states all digital outputs.
// R12: Output is straight binary: all ones +FS, all zeros -FS.
// R13: Capture side realigns banks via reset after any mode change; the testbench realigns only after the pin changes of its mode rows.
module adm_out_ctrl
    import adm_pkg::*;
#(
    parameter int DATA_W     = `ADM_DATA_W,
    parameter int FIFO_DEPTH = `ADM_FIFO_DEPTH
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    // Gray-coded comparator result of the sample taken this cycle
    input  wire logic [DATA_W-1:0] i_conv_gray,
    input  wire logic              i_conv_valid,
    output logic                   o_conv_ready,
    // Pins
    input  wire logic              i_output_mode_select_hi,
    input  wire logic              i_output_mode_select_lo,
    input  wire logic              i_power_down_input,
    input  wire logic              i_bank_align_rst,
    output logic [DATA_W-1:0]      o_output_bank_a,
    output logic                   o_output_bank_a_oe,
    output logic [DATA_W-1:0]      o_output_bank_b,
    output logic                   o_output_bank_b_oe,
    output logic                   o_output_data_clock_p,
    output logic                   o_output_data_clock_n,
    output logic                   o_output_data_clock_oe,
    output logic                   o_low_power,
    // Wishbone classic slave
    input  wire logic              i_wb_cyc,
    input  wire logic              i_wb_stb,
    input  wire logic              i_wb_we,
    input  wire logic [7:0]        i_wb_adr,
    input  wire logic [3:0]        i_wb_sel,
    input  wire logic [31:0]       i_wb_dat,
    output logic [31:0]            o_wb_dat,
    output logic                   o_wb_ack
);
    localparam int LW = $clog2(FIFO_DEPTH+1);

    // Gray to binary for a group of at most three bits
    function automatic logic [2:0] gray_dec3(input logic       upper,
                                             input logic [2:0] g);
        logic [2:0] b;
        b[2] = upper ^ g[2];
        b[1] = b[2] ^ g[1];
        b[0] = b[1] ^ g[0];
        return b;
    endfunction

    // Mode pin decode
    function automatic adm_mode_t mode_dec(input logic hi, input logic lo);
        if (hi) begin
            return ADM_MODE_SINGLE;
        end else if (lo) begin
            return ADM_MODE_ILV;
        end else begin
            return ADM_MODE_PAR;
        end
    endfunction

    logic [1:0]        hi_sync_q;
    logic [1:0]        lo_sync_q;
    logic [1:0]        pd_sync_q;
    logic [1:0]        al_sync_q;
    logic [31:0]       ctrl_q;
    logic              ack_q;
    logic [31:0]       rdat_q;
    adm_mode_t         mode;
    logic              pd_active;
    logic              adv;
    logic [2:0]        s0_msb_q;
    logic [4:0]        s0_gray_q;
    logic              s0_vld_q;
    logic [4:0]        s1_hi_q;
    logic [2:0]        s1_gray_q;
    logic              s1_vld_q;
    logic [2:0]        s1_mid;
    logic [DATA_W-1:0] s2_bin_q;
    logic              s2_vld_q;
    logic              fifo_in_rdy;
    logic              fifo_out_vld;
    logic [DATA_W-1:0] fifo_out_dat;
    logic [LW-1:0]     fifo_lvl;
    logic              drain;
    logic              phase_q;
    logic [DATA_W-1:0] a_hold_q;
    logic [DATA_W-1:0] bank_a_q;
    logic [DATA_W-1:0] bank_b_q;
    logic              oclk_q;
    logic              wb_hit;

    // Pin synchronisers, two flops each
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hi_sync_q <= 2'b00;
            lo_sync_q <= 2'b00;
            pd_sync_q <= 2'b00;
            al_sync_q <= 2'b00;
        end else begin
            hi_sync_q <= {hi_sync_q[0], i_output_mode_select_hi};
            lo_sync_q <= {lo_sync_q[0], i_output_mode_select_lo};
            pd_sync_q <= {pd_sync_q[0], i_power_down_input};
            al_sync_q <= {al_sync_q[0], i_bank_align_rst};
        end
    end

    // Mode from pins unless software overrides
    always_comb begin
        if (ctrl_q[`ADM_CTRL_MODE_OVR]) begin
            mode = mode_dec(ctrl_q[`ADM_CTRL_MODE_HI],
                            ctrl_q[`ADM_CTRL_MODE_LO]);
        end else begin
            mode = mode_dec(hi_sync_q[1], lo_sync_q[1]); // R4
        end
    end

    assign pd_active   = pd_sync_q[1] || ctrl_q[`ADM_CTRL_SOFT_PD];
    assign o_low_power = pd_active; // R11

    // Pipeline stalls on buffer back-pressure
    assign adv          = fifo_in_rdy && !pd_active;
    assign o_conv_ready = adv;

    // Stage 0: three MSBs decoded and latched
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s0_vld_q  <= 1'b0;
            s0_msb_q  <= 3'h0;
            s0_gray_q <= 5'h00;
        end else if (adv) begin
            s0_vld_q  <= i_conv_valid;
            s0_msb_q  <= gray_dec3(1'b0, i_conv_gray[7:5]); // R2
            s0_gray_q <= i_conv_gray[4:0];
        end
    end

    // Stage 1: middle two bits
    assign s1_mid = gray_dec3(s0_msb_q[0], {s0_gray_q[4:3], 1'b0}); // R2
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s1_vld_q  <= 1'b0;
            s1_hi_q   <= 5'h00;
            s1_gray_q <= 3'h0;
        end else if (adv) begin
            s1_vld_q  <= s0_vld_q;
            s1_hi_q   <= {s0_msb_q, s1_mid[2:1]}; // R2
            s1_gray_q <= s0_gray_q[2:0];
        end
    end

    // Stage 2: three LSBs, two cycles after the MSBs
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s2_vld_q <= 1'b0;
            s2_bin_q <= 8'h00;
        end else if (adv) begin
            s2_vld_q <= s1_vld_q;
            s2_bin_q <= {s1_hi_q, gray_dec3(s1_hi_q[0], s1_gray_q)}; // R3
        end
    end

    // Buffer between the converter pipeline and the bank steering
    adm_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) i_adm_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_flush     (1'b0),
        .i_in_valid  (s2_vld_q && adv),
        .o_in_ready  (fifo_in_rdy),
        .i_in_data   (s2_bin_q),
        .o_out_valid (fifo_out_vld),
        .i_out_ready (!pd_active),
        .o_out_data  (fifo_out_dat),
        .o_level     (fifo_lvl)
    );

    // Bank selection takes a straight binary sample each cycle the buffer holds one and power is up
    assign drain = fifo_out_vld && !pd_active; // R1 R12

    // Divide-by-two phase, aligned by the reset pin
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            phase_q <= 1'b0;
        end else if (al_sync_q[1]) begin
            phase_q <= 1'b0; // R9
        end else if (drain && mode != ADM_MODE_SINGLE) begin
            phase_q <= ~phase_q; // R8
        end else if (mode == ADM_MODE_SINGLE) begin
            phase_q <= 1'b0;
        end
    end

    // Bank steering per mode
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bank_a_q <= 8'h00;
            bank_b_q <= 8'h00;
            a_hold_q <= 8'h00;
        end else if (drain) begin
            case (mode)
                ADM_MODE_SINGLE: begin
                    bank_a_q <= fifo_out_dat; // R5
                end
                ADM_MODE_ILV: begin
                    if (!phase_q) begin
                        bank_a_q <= fifo_out_dat; // R6
                    end else begin
                        bank_b_q <= fifo_out_dat; // R6
                    end
                end
                default: begin
                    if (!phase_q) begin
                        a_hold_q <= fifo_out_dat; // R7
                    end else begin
                        bank_a_q <= a_hold_q; // R7
                        bank_b_q <= fifo_out_dat;
                    end
                end
            endcase
        end
    end

    // Output clock: toggles per sample in single, shows bank in dual
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            oclk_q <= 1'b0;
        end else if (drain) begin
            if (mode == ADM_MODE_SINGLE) begin
                oclk_q <= ~oclk_q; // R10
            end else begin
                oclk_q <= phase_q; // R10
            end
        end
    end

    // Pins float while powered down
    assign o_output_bank_a        = bank_a_q;
    assign o_output_bank_b        = bank_b_q;
    assign o_output_data_clock_p  = oclk_q;
    assign o_output_data_clock_n  = ~oclk_q;
    assign o_output_bank_a_oe     = !pd_active; // R11
    assign o_output_bank_b_oe     = !pd_active && mode != ADM_MODE_SINGLE;
    assign o_output_data_clock_oe = !pd_active; // R11

    // Wishbone: one wait state, every address answered
    assign wb_hit   = i_wb_cyc && i_wb_stb && !ack_q;
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_hit;
        end
    end

    // Control register writes, byte lane 0 only holds bits
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ctrl_q <= `ADM_CTRL_RST_VAL;
        end else if (wb_hit && i_wb_we && i_wb_sel[0]) begin
            if (i_wb_adr == `ADM_CTRL_OFS) begin
                ctrl_q <= {28'h000_0000, i_wb_dat[3:0]};
            end
        end
    end

    // Read data
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            rdat_q <= 32'h0000_0000;
        end else if (wb_hit && !i_wb_we) begin
            if (i_wb_adr == `ADM_CTRL_OFS) begin
                rdat_q <= ctrl_q;
            end else if (i_wb_adr == `ADM_STAT_OFS) begin
                rdat_q <= 32'h0000_0000;
                rdat_q[`ADM_STAT_MODE_LSB +: 2] <= mode;
                rdat_q[`ADM_STAT_PHASE] <= phase_q;
                rdat_q[`ADM_STAT_PD] <= pd_active;
                rdat_q[`ADM_STAT_LVL_MSB:`ADM_STAT_LVL_LSB] <= 4'(fifo_lvl);
            end else begin
                rdat_q <= 32'h0000_0000;
            end
        end
    end

endmodule

/* File: hw/adm_pkg.sv */
package adm_pkg;

    // Output bank arrangement
    typedef enum logic [1:0] {
        ADM_MODE_PAR    = 2'b00,
        ADM_MODE_ILV    = 2'b01,
        ADM_MODE_SINGLE = 2'b10
    } adm_mode_t;

endpackage

/* File: hw/adm_regs.svh */
`ifndef ADM_REGS_SVH
`define ADM_REGS_SVH

// Register byte offsets on the Wishbone slave
`define ADM_CTRL_OFS       8'h00
`define ADM_STAT_OFS       8'h04

// Control register fields
`define ADM_CTRL_SOFT_PD   0
`define ADM_CTRL_MODE_OVR  1
`define ADM_CTRL_MODE_LO   2
`define ADM_CTRL_MODE_HI   3
`define ADM_CTRL_RST_VAL   32'h0000_0000

// Status register fields
`define ADM_STAT_MODE_LSB  0
`define ADM_STAT_PHASE     2
`define ADM_STAT_PD        3
`define ADM_STAT_LVL_LSB   4
`define ADM_STAT_LVL_MSB   7

// Timing: latency in half sample cycles, sample clock in MHz
`define ADM_LAT_HALF       5
`define ADM_CLK_MHZ        25
`define ADM_LAT_CYC        ((`ADM_LAT_HALF + 1) / 2)

// Buffer in the data path
`define ADM_FIFO_DEPTH     8
`define ADM_DATA_W         8

`endif

/* File: sim/adm_capture.sv */
`timescale 1ns/1ps

module adm_capture #(
    parameter int DATA_W = 8
) (
    input  wire logic              i_sys_clk,
    input  wire logic [DATA_W-1:0] i_bank_a,
    input  wire logic              i_bank_a_oe,
    input  wire logic [DATA_W-1:0] i_bank_b,
    input  wire logic              i_bank_b_oe,
    input  wire logic              i_realign,
    output logic                   o_bank_align_rst
);
    logic [DATA_W-1:0] q[$];
    int                na;
    int                nb;
    logic [DATA_W-1:0] last_a_q;
    logic [DATA_W-1:0] last_b_q;
    logic [2:0]        hold_q = 3'h0;

    // Realign the divided clock for four cycles on each i_realign request
    always @(posedge i_sys_clk) begin
        if (i_realign)
            hold_q <= 3'h4;
        else if (hold_q != 3'h0)
            hold_q <= hold_q - 3'h1;
    end
    assign o_bank_align_rst = (hold_q != 3'h0);

    // Latch each new word on a driven bank, bank A first
    always @(posedge i_sys_clk) begin
        if (i_bank_a_oe && i_bank_a !== last_a_q) begin
            q.push_back(i_bank_a);
            na++;
        end
        if (i_bank_b_oe && i_bank_b !== last_b_q) begin
            q.push_back(i_bank_b);
            nb++;
        end
        last_a_q <= i_bank_a;
        last_b_q <= i_bank_b;
    end
endmodule

/* File: sim/adm_out_ctrl_asserts.sv */
`timescale 1ns/1ps

module adm_out_ctrl_asserts
    import adm_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic              i_sys_clk,
    input wire logic              i_rst,
    input wire logic              i_output_mode_select_hi,
    input wire logic              i_output_mode_select_lo,
    input wire logic              i_power_down_input,
    input wire logic              i_wb_cyc,
    input wire logic              i_wb_stb,
    input wire logic              o_conv_ready,
    input wire logic [DATA_W-1:0] o_output_bank_a,
    input wire logic              o_output_bank_a_oe,
    input wire logic [DATA_W-1:0] o_output_bank_b,
    input wire logic              o_output_bank_b_oe,
    input wire logic              o_output_data_clock_p,
    input wire logic              o_output_data_clock_n,
    input wire logic              o_output_data_clock_oe,
    input wire logic              o_low_power,
    input wire logic              o_wb_ack
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    // Pins held long enough to pass the synchronisers
    sequence s_single;
        i_output_mode_select_hi [*4];
    endsequence
    sequence s_ilv;
        (!i_output_mode_select_hi && i_output_mode_select_lo) [*6];
    endsequence
    sequence s_pd;
        i_power_down_input [*4];
    endsequence
    sequence s_par;
        (!i_output_mode_select_hi && !i_output_mode_select_lo) [*6];
    endsequence

    a_reset_values: assert property ($past(i_rst) |-> o_output_bank_a == '0
        && o_output_data_clock_n && !o_wb_ack)
        else $error("outputs wrong after reset");
    a_pd_tristate: assert property (s_pd |-> !o_output_bank_a_oe
        && !o_output_bank_b_oe && !o_output_data_clock_oe && o_low_power)
        else $error("outputs driven while powered down");
    a_pd_stall: assert property (s_pd |-> !o_conv_ready)
        else $error("pipeline takes samples while powered down");
    a_single_b_off: assert property (s_single |-> !o_output_bank_b_oe)
        else $error("bank b driven in single mode");
    a_single_clock: assert property (s_single
        ##0 $changed(o_output_bank_a) |-> $changed(o_output_data_clock_p))
        else $error("output clock idle for single mode sample");
    a_par_a_late: assert property (s_par ##0 $changed(o_output_bank_a)
        |-> o_output_data_clock_p)
        else $error("bank a update off the bank b phase");
    a_ilv_a_phase: assert property (s_ilv ##0 $changed(o_output_bank_a)
        |-> !o_output_data_clock_p)
        else $error("bank a update with clock high");
    a_ilv_b_phase: assert property (s_ilv ##0 $changed(o_output_bank_b)
        |-> o_output_data_clock_p)
        else $error("bank b update with clock low");
    a_clk_pair: assert property (o_output_data_clock_n
        == !o_output_data_clock_p)
        else $error("output clock pair not inverse");
    a_wb_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack)
        else $error("bus request not acknowledged next cycle");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("acknowledge longer than one cycle");
endmodule

bind adm_out_ctrl adm_out_ctrl_asserts #(
    .DATA_W (DATA_W)
) i_adm_out_ctrl_asserts (
    .i_sys_clk               (i_sys_clk),
    .i_rst                   (i_rst),
    .i_output_mode_select_hi (i_output_mode_select_hi),
    .i_output_mode_select_lo (i_output_mode_select_lo),
    .i_power_down_input      (i_power_down_input),
    .i_wb_cyc                (i_wb_cyc),
    .i_wb_stb                (i_wb_stb),
    .o_conv_ready            (o_conv_ready),
    .o_output_bank_a         (o_output_bank_a),
    .o_output_bank_a_oe      (o_output_bank_a_oe),
    .o_output_bank_b         (o_output_bank_b),
    .o_output_bank_b_oe      (o_output_bank_b_oe),
    .o_output_data_clock_p   (o_output_data_clock_p),
    .o_output_data_clock_n   (o_output_data_clock_n),
    .o_output_data_clock_oe  (o_output_data_clock_oe),
    .o_low_power             (o_low_power),
    .o_wb_ack                (o_wb_ack)
);

/* File: sim/tb_adm_out_ctrl.sv */
`timescale 1ns/1ps
`include "adm_regs.svh"

module tb_adm_out_ctrl;
    import adm_pkg::*;
    typedef struct { logic hi; logic lo; int na; int nb; } adm_row_t;
    logic i_sys_clk, i_rst, i_conv_valid, i_wb_cyc, i_wb_stb, i_wb_we;
    logic i_output_mode_select_hi, i_output_mode_select_lo, realign;
    logic i_power_down_input, i_bank_align_rst, o_conv_ready, o_wb_ack;
    logic o_output_bank_a_oe, o_output_bank_b_oe, o_low_power;
    logic o_output_data_clock_p, o_output_data_clock_n;
    logic o_output_data_clock_oe;
    logic [7:0]  i_conv_gray, i_wb_adr, o_output_bank_a, o_output_bank_b;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, rd;
    int          errors, checks;
    adm_row_t    rows[4] = '{'{1, 0, 4, 0}, '{1, 1, 4, 0},
                            '{0, 1, 2, 2}, '{0, 0, 2, 2}};
    logic [7:0]  smp[4] = '{8'hFF, 8'h01, 8'h80, 8'h00};

    adm_out_ctrl i_adm_out_ctrl (
        .i_sys_clk, .i_rst, .i_conv_gray, .i_conv_valid, .o_conv_ready,
        .i_output_mode_select_hi, .i_output_mode_select_lo,
        .i_power_down_input, .i_bank_align_rst,
        .o_output_bank_a, .o_output_bank_a_oe,
        .o_output_bank_b, .o_output_bank_b_oe,
        .o_output_data_clock_p, .o_output_data_clock_n,
        .o_output_data_clock_oe, .o_low_power,
        .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
        .o_wb_dat, .o_wb_ack);
    adm_capture i_adm_capture (.i_sys_clk, .i_bank_a(o_output_bank_a),
        .i_bank_a_oe(o_output_bank_a_oe), .i_bank_b(o_output_bank_b),
        .i_bank_b_oe(o_output_bank_b_oe), .i_realign(realign),
        .o_bank_align_rst(i_bank_align_rst));

    // Sample clock, 40 ns period
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic single bus cycle, held until acknowledge is sampled
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        int n;
        @(posedge i_sys_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we} <= {1'b1, 1'b1, we};
        i_wb_adr <= adr;
        i_wb_dat <= dat;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 50);
        if (o_wb_ack !== 1'b1) errors++;
        rd = o_wb_dat;
        {i_wb_cyc, i_wb_stb} <= 2'b00;
    endtask

    // Offer one gray-coded sample until the pipeline takes it
    task automatic put(input logic [7:0] b);
        int n;
        i_conv_gray <= b ^ (b >> 1);
        i_conv_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_conv_ready !== 1'b1 && n < 50);
        if (o_conv_ready !== 1'b1) errors++;
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {i_rst, i_conv_valid, i_wb_cyc, i_wb_stb, i_wb_we} = 5'h10;
        {i_output_mode_select_hi, i_output_mode_select_lo} = 2'b00;
        {i_power_down_input, realign} = 2'b00;
        {i_conv_gray, i_wb_adr, i_wb_sel, i_wb_dat} = '0;
        i_wb_sel = 4'hF;
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(negedge i_sys_clk);
        chk("bank_a", o_output_bank_a, 8'h00);
        chk("clock_n", o_output_data_clock_n, 1'b1);
        wb(1'b0, `ADM_CTRL_OFS, 32'h0);
        chk("ctrl", rd, `ADM_CTRL_RST_VAL);
        wb(1'b0, 8'h08, 32'h0);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
        // Every mode code streams the same words through
        foreach (rows[r]) begin
            @(posedge i_sys_clk);
            i_output_mode_select_hi <= rows[r].hi;
            i_output_mode_select_lo <= rows[r].lo;
            repeat (4) @(posedge i_sys_clk);
            realign <= 1'b1;
            @(posedge i_sys_clk);
            realign <= 1'b0;
            repeat (10) @(posedge i_sys_clk);
            i_adm_capture.q.delete();
            {i_adm_capture.na, i_adm_capture.nb} = '0;
            foreach (smp[k]) put(smp[k]);
            i_conv_valid <= 1'b0;
            repeat (12) @(posedge i_sys_clk);
            chk("count", i_adm_capture.q.size(), 4);
            foreach (smp[k]) chk("word", i_adm_capture.q[k], smp[k]);
            chk("bank_a_n", i_adm_capture.na, rows[r].na);
            chk("bank_b_n", i_adm_capture.nb, rows[r].nb);
            $display("test mode row %0d done", r);
        end
        // Latency to bank A in single mode
        @(posedge i_sys_clk);
        i_output_mode_select_hi <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        put(8'h55);
        i_conv_valid <= 1'b0;
        repeat (4) @(negedge i_sys_clk);
        chk("early", o_output_bank_a, 8'h80);
        @(negedge i_sys_clk);
        chk("on_time", o_output_bank_a, 8'h55);
        $display("test latency done");
        // Power-down pin
        @(posedge i_sys_clk);
        i_power_down_input <= 1'b1;
        repeat (5) @(negedge i_sys_clk);
        chk("oe", {o_output_bank_a_oe, o_output_bank_b_oe}, 2'b00);
        chk("clock_oe", o_output_data_clock_oe, 1'b0);
        chk("low_power", o_low_power, 1'b1);
        chk("ready", o_conv_ready, 1'b0);
        @(posedge i_sys_clk);
        {i_power_down_input, i_output_mode_select_hi} <= 2'b00;
        repeat (5) @(negedge i_sys_clk);
        chk("oe_back", o_output_bank_a_oe, 1'b1);
        $display("test power down done");
        // Register controls: soft power-down, then mode override
        wb(1'b1, `ADM_CTRL_OFS, 32'h0000_0001);
        wb(1'b0, `ADM_STAT_OFS, 32'h0);
        chk("stat_pd", rd[`ADM_STAT_PD], 1'b1);
        chk("soft_low_power", o_low_power, 1'b1);
        wb(1'b1, `ADM_CTRL_OFS, 32'h0000_0006);
        wb(1'b0, `ADM_CTRL_OFS, 32'h0);
        chk("ctrl_back", rd, 32'h0000_0006);
        wb(1'b0, `ADM_STAT_OFS, 32'h0);
        chk("stat_mode", rd[1:0], ADM_MODE_ILV);
        $display("test registers done");
        tally_and_finish();
    end
endmodule
